// File: common/pfag_defs.svh
// Address map, protection classes and wait counts of the peripheral frame guard.
// Assumes word (16-bit) addressing of a 22-bit core data space.
`ifndef PFAG_DEFS_SVH
`define PFAG_DEFS_SVH

// Region entry: {low word, high word, frame, protection class, security gated}
// Protection class: 0 none, 1 whole region, 2 low control words of a CAN block
`define PFAG_NUM_RGN 27
`define PFAG_RGN_00 {16'h0880, 16'h09ff, 2'h0, 2'h1, 1'b0}
`define PFAG_RGN_01 {16'h0a80, 16'h0adf, 2'h0, 2'h1, 1'b1}
`define PFAG_RGN_02 {16'h0ae0, 16'h0aef, 2'h0, 2'h1, 1'b0}
`define PFAG_RGN_03 {16'h0b00, 16'h0b0f, 2'h0, 2'h0, 1'b0}
`define PFAG_RGN_04 {16'h0c00, 16'h0c3f, 2'h0, 2'h0, 1'b0}
`define PFAG_RGN_05 {16'h0ce0, 16'h0cff, 2'h0, 2'h0, 1'b0}
`define PFAG_RGN_06 {16'h0d00, 16'h0dff, 2'h0, 2'h1, 1'b0}
`define PFAG_RGN_07 {16'h6000, 16'h60ff, 2'h1, 2'h2, 1'b0}
`define PFAG_RGN_08 {16'h6100, 16'h61ff, 2'h1, 2'h0, 1'b0}
`define PFAG_RGN_09 {16'h6200, 16'h62ff, 2'h1, 2'h2, 1'b0}
`define PFAG_RGN_10 {16'h6300, 16'h63ff, 2'h1, 2'h0, 1'b0}
`define PFAG_RGN_11 {16'h6800, 16'h697f, 2'h1, 2'h0, 1'b0}
`define PFAG_RGN_12 {16'h6a00, 16'h6a7f, 2'h1, 2'h0, 1'b0}
`define PFAG_RGN_13 {16'h6b00, 16'h6b7f, 2'h1, 2'h0, 1'b0}
`define PFAG_RGN_14 {16'h6f80, 16'h6fbf, 2'h1, 2'h1, 1'b0}
`define PFAG_RGN_15 {16'h6fc0, 16'h6fdf, 2'h1, 2'h0, 1'b0}
`define PFAG_RGN_16 {16'h6fe0, 16'h6fff, 2'h1, 2'h1, 1'b0}
`define PFAG_RGN_17 {16'h7010, 16'h702f, 2'h2, 2'h1, 1'b0}
`define PFAG_RGN_18 {16'h7040, 16'h704f, 2'h2, 2'h0, 1'b0}
`define PFAG_RGN_19 {16'h7050, 16'h705f, 2'h2, 2'h0, 1'b0}
`define PFAG_RGN_20 {16'h7070, 16'h707f, 2'h2, 2'h0, 1'b0}
`define PFAG_RGN_21 {16'h7100, 16'h711f, 2'h2, 2'h0, 1'b0}
`define PFAG_RGN_22 {16'h7740, 16'h774f, 2'h2, 2'h0, 1'b0}
`define PFAG_RGN_23 {16'h7750, 16'h775f, 2'h2, 2'h0, 1'b0}
`define PFAG_RGN_24 {16'h7760, 16'h776f, 2'h2, 2'h0, 1'b0}
`define PFAG_RGN_25 {16'h7780, 16'h778f, 2'h2, 2'h0, 1'b0}
`define PFAG_RGN_26 {16'h7900, 16'h792f, 2'h2, 2'h0, 1'b0}

// Highest word offset inside a CAN register block that is lock protected
`define PFAG_CAN_PROT_TOP 8'h1f
// Peripheral space lies in the low 64K words
`define PFAG_HI_PAGE      6'h00
// Wait counts in clock cycles, and the write lock value loaded at reset
`define PFAG_RD_WAIT_F12  2'h2
`define PFAG_WR_WAIT_B2B  2'h1
`define PFAG_NO_WAIT      2'h0
`define PFAG_LOCK_RST     1'b1

`endif

// File: common/pfag_pkg.sv
// Types shared by the peripheral frame guard.
// Assumes pfag_defs.svh supplies the numeric map.
package pfag_pkg;

  typedef enum logic [1:0] {
    PFAG_FR0  = 2'h0,
    PFAG_FR1  = 2'h1,
    PFAG_FR2  = 2'h2,
    PFAG_FRNA = 2'h3
  } pfag_frame_t;

  typedef enum logic [1:0] {
    PFAG_PR_NONE = 2'h0,
    PFAG_PR_FULL = 2'h1,
    PFAG_PR_CAN  = 2'h2,
    PFAG_PR_RSV  = 2'h3
  } pfag_prot_t;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
    pfag_frame_t frame;
    pfag_prot_t  prot;
    logic        secure;
  } pfag_rgn_t;

  typedef struct packed {
    logic [21:0] addr;
    logic        we;
    logic        wide;
    logic [31:0] wdata;
  } pfag_req_t;

  typedef struct packed {
    logic        sel;
    logic        we;
    logic        wide;
    logic [15:0] addr;
    logic [31:0] wdata;
  } pfag_port_t;

  typedef enum logic [1:0] {
    PFAG_IDLE = 2'b00,
    PFAG_BUSY = 2'b01,
    PFAG_DONE = 2'b11
  } pfag_state_t;

endpackage : pfag_pkg

// File: hw/pfag_guard.sv
// Peripheral frame guard: decodes core data accesses onto three peripheral
// frames and gates them by write lock, code security and access width.
// Assumes one core access at a time, held stable while core_req_valid is high
// until core_ready; peripheral read data is valid while its select is high.
`timescale 1ns/10ps
`default_nettype none
`include "pfag_defs.svh"

module pfag_guard
  import pfag_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        core_req_valid,
  input  wire pfag_req_t   core_req,
  input  wire logic        protect_unlock_instr,
  input  wire logic        protect_relock_instr,
  input  wire logic        code_security_gate,
  input  wire logic [31:0] f0_rdata,
  input  wire logic [31:0] f1_rdata,
  input  wire logic [15:0] f2_rdata,
  output logic             core_ready,
  output logic [31:0]      core_rdata,
  output logic             access_dropped,
  output logic             write_lock,
  output pfag_port_t       f0_port,
  output pfag_port_t       f1_port,
  output pfag_port_t       f2_port
);

  localparam int NRGN = `PFAG_NUM_RGN;
  localparam pfag_rgn_t RGN [NRGN] = '{
    `PFAG_RGN_00, `PFAG_RGN_01, `PFAG_RGN_02, `PFAG_RGN_03, `PFAG_RGN_04,
    `PFAG_RGN_05, `PFAG_RGN_06, `PFAG_RGN_07, `PFAG_RGN_08, `PFAG_RGN_09,
    `PFAG_RGN_10, `PFAG_RGN_11, `PFAG_RGN_12, `PFAG_RGN_13, `PFAG_RGN_14,
    `PFAG_RGN_15, `PFAG_RGN_16, `PFAG_RGN_17, `PFAG_RGN_18, `PFAG_RGN_19,
    `PFAG_RGN_20, `PFAG_RGN_21, `PFAG_RGN_22, `PFAG_RGN_23, `PFAG_RGN_24,
    `PFAG_RGN_25, `PFAG_RGN_26
  };

  pfag_state_t state_ff;
  pfag_state_t nxt_state;
  logic        lock_ff;
  logic [1:0]  cnt_ff;
  logic        last_f1_wr_ff;
  logic        dropped_ff;
  logic [31:0] rdata_ff;
  pfag_port_t  f0_ff;
  pfag_port_t  f1_ff;
  pfag_port_t  f2_ff;
  logic [NRGN-1:0] hit;
  pfag_rgn_t   rgn;

  // Region hit per table entry; gaps and the upper pages match nothing
  genvar gi;
  generate
    for (gi = 0; gi < NRGN; gi++) begin : g_hit
      assign hit[gi] = (core_req.addr[21:16] == `PFAG_HI_PAGE) &&
                       (core_req.addr[15:0] >= RGN[gi].lo) &&
                       (core_req.addr[15:0] <= RGN[gi].hi);
    end
  endgenerate

  function automatic pfag_rgn_t pick_rgn(input logic [NRGN-1:0] h);
    pfag_rgn_t r;
    r = '{lo: 16'h0000, hi: 16'h0000, frame: PFAG_FRNA, prot: PFAG_PR_NONE, secure: 1'b0};
    for (int i = 0; i < NRGN; i++) begin
      if (h[i]) begin
        r = RGN[i];
      end
    end
    return r;
  endfunction : pick_rgn

  assign rgn = pick_rgn(hit);

  wire accept    = (state_ff == PFAG_IDLE) && core_req_valid;
  wire is_f0     = (rgn.frame == PFAG_FR0);
  wire is_f1     = (rgn.frame == PFAG_FR1);
  wire is_f2     = (rgn.frame == PFAG_FR2);
  // CAN blocks lock only their low control words; mailboxes never match this
  wire can_ctl   = (rgn.prot == PFAG_PR_CAN) && (core_req.addr[7:0] <= `PFAG_CAN_PROT_TOP);
  wire prot_need = (rgn.prot == PFAG_PR_FULL) || can_ctl;
  wire lock_blk  = core_req.we && prot_need && lock_ff;
  wire sec_blk   = rgn.secure && !code_security_gate;
  wire width_blk = is_f2 && core_req.wide;
  wire issue     = (rgn.frame != PFAG_FRNA) && !lock_blk && !sec_blk && !width_blk;
  wire b2b_wr    = core_req.we && is_f1 && last_f1_wr_ff;

  // Read waits on frames 1 and 2, one extra cycle for a repeated frame 1 write
  wire [1:0] nxt_cnt = (!core_req.we && (is_f1 || is_f2)) ? `PFAG_RD_WAIT_F12 :
                       b2b_wr ? `PFAG_WR_WAIT_B2B : `PFAG_NO_WAIT;

  // Strobe carries the width; frame 2 is a 16-bit bus and is never selected for a wide access
  wire pfag_port_t nxt_port = '{sel: 1'b0, we: core_req.we, wide: core_req.wide,
                                addr: core_req.addr[15:0], wdata: core_req.wdata};
  wire last_busy = (state_ff == PFAG_BUSY) && (cnt_ff == 2'h0);

  wire [31:0] sel_rdata = f0_ff.sel ? f0_rdata :
                          f1_ff.sel ? f1_rdata :
                          f2_ff.sel ? {16'h0000, f2_rdata} : 32'h0000_0000;
  // Dropped reads return zero; writes return zero too
  wire [31:0] nxt_rdata = (!f0_ff.we && !f1_ff.we && !f2_ff.we) ? sel_rdata : 32'h0000_0000;

  always_comb begin
    case (state_ff)
      PFAG_IDLE: nxt_state = accept ? PFAG_BUSY : PFAG_IDLE;
      PFAG_BUSY: nxt_state = (cnt_ff == 2'h0) ? PFAG_DONE : PFAG_BUSY;
      PFAG_DONE: nxt_state = PFAG_IDLE;
      default:   nxt_state = PFAG_IDLE;
    endcase
  end

  // Relock wins when both instructions land in one cycle
  wire nxt_lock = protect_relock_instr ? 1'b1 : protect_unlock_instr ? 1'b0 : lock_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= PFAG_IDLE;
      lock_ff  <= `PFAG_LOCK_RST;
    end else begin
      state_ff <= nxt_state;
      lock_ff  <= nxt_lock;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_ff        <= 2'h0;
      last_f1_wr_ff <= 1'b0;
      dropped_ff    <= 1'b0;
    end else if (accept) begin
      cnt_ff        <= nxt_cnt;
      last_f1_wr_ff <= core_req.we && is_f1;
      dropped_ff    <= !issue;
    end else if (state_ff == PFAG_BUSY && cnt_ff != 2'h0) begin
      cnt_ff        <= cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (last_busy) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Blocked or ignored accesses raise no select but still complete on time
  always_ff @(posedge clock) begin
    if (!rst_n || last_busy) begin
      f0_ff <= '0;
      f1_ff <= '0;
      f2_ff <= '0;
    end else if (accept) begin
      f0_ff     <= nxt_port;
      f1_ff     <= nxt_port;
      f2_ff     <= nxt_port;
      f0_ff.sel <= issue && is_f0;
      f1_ff.sel <= issue && is_f1;
      f2_ff.sel <= issue && is_f2;
    end
  end

  assign core_ready     = (state_ff == PFAG_DONE);
  assign core_rdata     = rdata_ff;
  assign access_dropped = dropped_ff && core_ready;
  assign write_lock     = lock_ff;
  assign f0_port        = f0_ff;
  assign f1_port        = f1_ff;
  assign f2_port        = f2_ff;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  lock_on_relock_a: assert property (protect_relock_instr |=> lock_ff)
    else $error("relock did not set the write lock");
  lock_off_unlock_a: assert property (protect_unlock_instr && !protect_relock_instr
                                      |=> !lock_ff)
    else $error("unlock did not clear the write lock");
  locked_write_dropped_a: assert property (accept && lock_blk
                                           |=> !f0_ff.sel && !f1_ff.sel && !f2_ff.sel)
    else $error("locked write reached a frame");
  secure_gate_a: assert property (accept && sec_blk
                                  |=> !f0_ff.sel ##1 core_ready && access_dropped)
    else $error("security gated access not dropped");
  frame2_narrow_a: assert property (f2_ff.sel |-> !f2_ff.wide)
    else $error("wide access on frame 2 bus");
  read_wait_a: assert property (accept && !core_req.we && (is_f1 || is_f2)
                                |-> !core_ready [*4] ##1 core_ready)
    else $error("frame 1/2 read wait wrong");
  b2b_write_a: assert property (accept && b2b_wr
                                |=> !core_ready ##1 !core_ready ##1 core_ready)
    else $error("back-to-back frame 1 write delay wrong");
  mailbox_open_a: assert property (accept && core_req.we && is_f1
                                   && rgn.prot == PFAG_PR_NONE |=> f1_ff.sel && f1_ff.we)
    else $error("unprotected frame 1 write blocked");
  frame0_wide_a: assert property (accept && is_f0 && core_req.wide
                                  && !sec_blk && !lock_blk
                                  |=> f0_ff.sel && f0_ff.wide ##1 core_ready)
    else $error("frame 0 wide access not passed");
  dropped_write_time_a: assert property (accept && lock_blk && !is_f1
                                         |=> ##1 core_ready && access_dropped)
    else $error("blocked write did not complete silently");

  cov_locked_write_c:  cover property (accept && lock_blk);
  cov_f1_b2b_c:        cover property (accept && b2b_wr);
  cov_f2_read_c:       cover property (accept && is_f2 && !core_req.we ##4 core_ready);
  cov_unlock_write_c:  cover property (protect_unlock_instr ##[1:20]
                                       (accept && prot_need && core_req.we && issue));

endmodule : pfag_guard
`default_nettype wire

// File: tb/pfag_periph_model.sv
// Model of the three peripheral frames: answers reads on the frame ports.
// Assumes the guard holds sel with addr steady for the whole access.
`timescale 1ns/10ps
`default_nettype none
module pfag_periph_model
  import pfag_pkg::*;
(
  input  wire logic        clock,
  input  wire pfag_port_t  f0_port,
  input  wire pfag_port_t  f1_port,
  input  wire pfag_port_t  f2_port,
  output logic [31:0]      f0_rdata,
  output logic [31:0]      f1_rdata,
  output logic [15:0]      f2_rdata
);
  logic [31:0] junk_ff = 32'h0;
  // Unselected frames show changing data so a stale value cannot pass
  always @(posedge clock) begin
    junk_ff <= ~junk_ff ^ 32'h5a5a_0f0f;
  end
  assign f0_rdata = f0_port.sel ? {f0_port.addr, ~f0_port.addr} : junk_ff;
  assign f1_rdata = f1_port.sel ? {~f1_port.addr, f1_port.addr} : junk_ff;
  assign f2_rdata = f2_port.sel ? f2_port.addr : junk_ff[15:0];
endmodule : pfag_periph_model
`default_nettype wire

// File: tb/peripheral_frame_access_guard_tb.sv
// Self-checking bench of the peripheral frame guard.
// Assumes pfag_periph_model answers frame reads from the port address.
`timescale 1ns/10ps
`default_nettype none
module peripheral_frame_access_guard_tb
  import pfag_pkg::*;
;
  logic        clock, rst_n, core_req_valid, core_ready, access_dropped, write_lock;
  logic        protect_unlock_instr, protect_relock_instr, code_security_gate;
  logic [31:0] f0_rdata, f1_rdata, core_rdata;
  logic [15:0] f2_rdata;
  pfag_req_t   core_req;
  pfag_port_t  f0_port, f1_port, f2_port;
  int          fail_count = 0;
  int          samples_checked = 0;

  pfag_guard dut_u (.clock(clock), .rst_n(rst_n), .core_req_valid(core_req_valid),
    .core_req(core_req), .protect_unlock_instr(protect_unlock_instr),
    .protect_relock_instr(protect_relock_instr), .code_security_gate(code_security_gate),
    .f0_rdata(f0_rdata), .f1_rdata(f1_rdata), .f2_rdata(f2_rdata), .core_ready(core_ready),
    .core_rdata(core_rdata), .access_dropped(access_dropped), .write_lock(write_lock),
    .f0_port(f0_port), .f1_port(f1_port), .f2_port(f2_port));
  pfag_periph_model peri_u (.clock(clock), .f0_port(f0_port), .f1_port(f1_port),
    .f2_port(f2_port), .f0_rdata(f0_rdata), .f1_rdata(f1_rdata), .f2_rdata(f2_rdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One core access held until core_ready; n counts cycles after acceptance
  task automatic xp(input logic [21:0] a, input logic w, input logic wd, input int lat,
                    input logic drop);
    int          n;
    int          ns;
    logic        sl;
    logic [2:0]  fs;
    logic [2:0]  ef;
    logic [31:0] ex;
    logic [31:0] pw;
    logic [31:0] ew;
    pfag_port_t  pp;
    n = 0;
    ns = 0;
    sl = 1'b0;
    fs = 3'h0;
    pp = '0;
    core_req = '{addr: a, we: w, wide: wd, wdata: {~a[15:0], a[15:0]}};
    core_req_valid = 1'b1;
    while (n < 8 && core_ready !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
      sl = sl | f0_port.sel | f1_port.sel | f2_port.sel;
      fs = fs | {f2_port.sel, f1_port.sel, f0_port.sel};
      ns = ns + (f0_port.sel | f1_port.sel | f2_port.sel);
      if (f0_port.sel) pp = f0_port;
      if (f1_port.sel) pp = f1_port;
      if (f2_port.sel) pp = f2_port;
    end
    ex = (a[15:0] < 16'h6000) ? {a[15:0], ~a[15:0]} : {~a[15:0], a[15:0]};
    if (w || drop) ex = 32'h0;
    ef = (a[15:0] < 16'h6000) ? 3'h1 : (a[15:0] < 16'h7000) ? 3'h2 : 3'h4;
    if (drop) ef = 3'h0;
    pw = wd ? pp.wdata : {16'h0000, pp.wdata[15:0]};
    ew = wd ? {~a[15:0], a[15:0]} : {16'h0000, a[15:0]};
    check(n, lat);
    check(access_dropped, drop);
    check(sl, !drop);
    check(fs, ef);
    check(ns, drop ? 0 : lat - 1);
    if (!drop) check({pp.we, pp.wide, pp.addr}, {w, wd, a[15:0]});
    if (w && !drop) check(pw, ew);
    if (wd) check(core_rdata, ex);
    else check(core_rdata[15:0], ex[15:0]);
    @(posedge clock);
    #1;
    core_req_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask : xp

  task automatic pulse(input logic u, input logic r, input logic exp);
    protect_unlock_instr = u;
    protect_relock_instr = r;
    @(posedge clock);
    #1;
    protect_unlock_instr = 1'b0;
    protect_relock_instr = 1'b0;
    check(write_lock, exp);
  endtask : pulse

  task automatic t_reset;
    check({core_ready, access_dropped, write_lock}, 3'h1);
    check(core_rdata, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_frame0;
    xp(22'h000b00, 1'b1, 1'b0, 2, 1'b0);
    xp(22'h000b02, 1'b1, 1'b1, 2, 1'b0);
    xp(22'h000c00, 1'b0, 1'b1, 2, 1'b0);
    xp(22'h000c01, 1'b0, 1'b0, 2, 1'b0);
    $display("test frame0 done");
  endtask : t_frame0

  task automatic t_lock;
    xp(22'h000d00, 1'b1, 1'b0, 2, 1'b1);
    xp(22'h000d00, 1'b0, 1'b0, 2, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    xp(22'h000d00, 1'b1, 1'b0, 2, 1'b0);
    xp(22'h000880, 1'b1, 1'b1, 2, 1'b0);
    pulse(1'b0, 1'b1, 1'b1);
    xp(22'h000d10, 1'b1, 1'b0, 2, 1'b1);
    pulse(1'b1, 1'b1, 1'b1);
    $display("test lock done");
  endtask : t_lock

  task automatic t_secure;
    xp(22'h000a80, 1'b1, 1'b0, 2, 1'b1);
    pulse(1'b1, 1'b0, 1'b0);
    code_security_gate = 1'b0;
    xp(22'h000a80, 1'b1, 1'b0, 2, 1'b1);
    xp(22'h000adf, 1'b0, 1'b0, 2, 1'b1);
    code_security_gate = 1'b1;
    xp(22'h000a80, 1'b1, 1'b0, 2, 1'b0);
    xp(22'h000adf, 1'b0, 1'b0, 2, 1'b0);
    pulse(1'b0, 1'b1, 1'b1);
    $display("test security done");
  endtask : t_secure

  // CAN accesses stay 32-bit at even addresses
  task automatic t_frames12;
    xp(22'h006000, 1'b1, 1'b1, 2, 1'b1);
    xp(22'h006a00, 1'b0, 1'b1, 4, 1'b0);
    xp(22'h006fe0, 1'b1, 1'b0, 2, 1'b1);
    xp(22'h006020, 1'b0, 1'b1, 4, 1'b0);
    xp(22'h006020, 1'b1, 1'b1, 2, 1'b0);
    xp(22'h006100, 1'b1, 1'b1, 3, 1'b0);
    xp(22'h006fc0, 1'b1, 1'b0, 3, 1'b0);
    xp(22'h007040, 1'b0, 1'b0, 4, 1'b0);
    xp(22'h007040, 1'b1, 1'b1, 2, 1'b1);
    xp(22'h007010, 1'b1, 1'b0, 2, 1'b1);
    xp(22'h007041, 1'b1, 1'b0, 2, 1'b0);
    xp(22'h00621e, 1'b1, 1'b1, 2, 1'b1);
    xp(22'h006220, 1'b1, 1'b1, 3, 1'b0);
    xp(22'h000a00, 1'b0, 1'b0, 2, 1'b1);
    pulse(1'b1, 1'b0, 1'b0);
    xp(22'h006fe0, 1'b1, 1'b0, 2, 1'b0);
    xp(22'h006000, 1'b1, 1'b1, 3, 1'b0);
    $display("test frames12 done");
  endtask : t_frames12

  // Reset in mid access: lock re-arms and the frame 1 write history is cleared
  task automatic t_midreset;
    core_req = '{addr: 22'h006100, we: 1'b1, wide: 1'b1, wdata: 32'h0000_0000};
    core_req_valid = 1'b1;
    @(posedge clock);
    #1;
    rst_n = 1'b0;
    core_req_valid = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    check({core_ready, access_dropped, write_lock, f1_port.sel}, 4'h2);
    xp(22'h006100, 1'b1, 1'b1, 2, 1'b0);
    $display("test midreset done");
  endtask : t_midreset

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    #(2000 * 50);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    core_req_valid = 1'b0;
    core_req = '0;
    protect_unlock_instr = 1'b0;
    protect_relock_instr = 1'b0;
    code_security_gate = 1'b1;
    repeat (16) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_frame0();
    t_lock();
    t_secure();
    t_frames12();
    t_midreset();
    tally_and_finish();
  end
endmodule : peripheral_frame_access_guard_tb
`default_nettype wire
